// >>> sacf_consts.vh
// register map, field positions, codes and counts of the sar adc control front end
`ifndef SACF_CONSTS_VH
`define SACF_CONSTS_VH
`define SACF_OFF_CTRL1 12'h000
`define SACF_OFF_CTRL2 12'h004
`define SACF_OFF_RESULT 12'h008
`define SACF_OFF_CMPVAL 12'h00C
`define SACF_OFF_CFG 12'h010
`define SACF_C1_CONT 5
`define SACF_C1_IEN 6
`define SACF_C2_CMP_GTE 4
`define SACF_C2_CMP_EN 5
`define SACF_C2_HWT 6
`define SACF_CFG_MODE8 2
`define SACF_CFG_LONG 3
`define SACF_CFG_LOWPOW 6
`define SACF_RST_CHAN 5'h1F
`define SACF_RST_CFG 7'h00
`define SACF_RST_SRC 2'h0
`define SACF_CH_PIN_MAX 5'h0F
`define SACF_CH_GND_MAX 5'h15
`define SACF_CH_TEMP 5'h1A
`define SACF_CH_BGAP 5'h1B
`define SACF_CH_VREFH 5'h1D
`define SACF_CH_VREFL 5'h1E
`define SACF_CH_OFF 5'h1F
`define SACF_RT_PIN 3'h0
`define SACF_RT_GND 3'h1
`define SACF_RT_TEMP 3'h2
`define SACF_RT_BGAP 3'h3
`define SACF_RT_VREFH 3'h4
`define SACF_RT_VREFL 3'h5
`define SACF_RT_RSVD 3'h6
`define SACF_RT_OFF 3'h7
`define SACF_SRC_BUS 2'h0
`define SACF_SRC_BUS2 2'h1
`define SACF_SRC_LOCAL 2'h2
`define SACF_SRC_ALT 2'h3
`define SACF_SAMP_SHORT 5'h04
`define SACF_SAMP_LONG 5'h18
`endif

// >>> sacf_clkgen.v
// conversion clock enable generator: source select, synchronisers and divider
`default_nettype none
`include "sacf_consts.vh"
module sacf_clkgen (
   // clock and reset
   input wire pclk,
   input wire presetn,
   // control
   input wire run,
   input wire [1:0] src,
   input wire [1:0] div,
   input wire light_stop,
   // raw clock sources
   input wire local_osc,
   input wire external_reference_clock,
   // conversion clock enable
   output reg conv_en
);
   reg loc_s1_r, loc_s2_r, loc_s3_r;
   reg alt_s1_r, alt_s2_r, alt_s3_r;
   reg half_r;
   reg [2:0] cnt_r;
   reg tick;
   wire [2:0] last = (3'h1 << div) - 3'h1;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         loc_s1_r <= 1'b0;
         loc_s2_r <= 1'b0;
         loc_s3_r <= 1'b0;
         alt_s1_r <= 1'b0;
         alt_s2_r <= 1'b0;
         alt_s3_r <= 1'b0;
      end else begin
         // local and alternate clocks enter the bus domain here
         loc_s1_r <= local_osc;
         loc_s2_r <= loc_s1_r;
         loc_s3_r <= loc_s2_r;
         alt_s1_r <= external_reference_clock;
         alt_s2_r <= alt_s1_r;
         alt_s3_r <= alt_s2_r;
      end
   end

   // four selectable sources
   always @* begin
      case (src)
         `SACF_SRC_BUS: tick = 1'b1;
         `SACF_SRC_BUS2: tick = half_r;
         `SACF_SRC_LOCAL: tick = loc_s2_r & ~loc_s3_r;
         // alternate clock usable in wait, never in stop
         `SACF_SRC_ALT: tick = alt_s2_r & ~alt_s3_r & ~light_stop;
         default: tick = 1'b0;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         half_r <= 1'b0;
         cnt_r <= 3'h0;
         conv_en <= 1'b0;
      end else begin
         half_r <= ~half_r;
         conv_en <= 1'b0;
         if (!run) begin
            cnt_r <= 3'h0;
         end else if (tick) begin
            // divide by 1, 2, 4 or 8
            if (cnt_r == last) begin
               cnt_r <= 3'h0;
               conv_en <= 1'b1;
            end else begin
               cnt_r <= cnt_r + 3'h1;
            end
         end
      end
   end
endmodule // sacf_clkgen
`default_nettype wire

// >>> sacf_top.v
// sar adc control front end: apb registers, channel routing, triggering and sar sequencer
//
// Register access over APB and the address map were chosen for this implementation.
`default_nettype none
`include "sacf_consts.vh"
module sacf_top #(
   parameter RES_W = 10,
   parameter ADDR_W = 12
) (
   // apb slave
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [ADDR_W-1:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // clock sources and trigger
   input wire local_osc,
   input wire external_reference_clock,
   input wire hardware_trigger_input,
   // power modes
   input wire light_stop_mode,
   input wire deep_stop_mode,
   // analog side
   input wire sar_cmp,
   output reg [3:0] pin_sel_r,
   output reg [2:0] route_r,
   output reg conv_on_r,
   output reg sample_r,
   output reg [RES_W-1:0] dac_r,
   output reg irq_r
);
   localparam ST_IDLE = 3'h1;
   localparam ST_SAMP = 3'h2;
   localparam ST_CONV = 3'h4;

   // software state
   reg [4:0] chan_r;
   reg cont_r, ien_r, done_r;
   reg cmp_gte_r, cmp_en_r, hwt_r;
   reg [1:0] src_r, div_r;
   reg mode8_r, long_r, lowpow_r;
   reg [RES_W-1:0] cmpval_r, result_r;
   // sequencer state
   reg [2:0] st_r, st_nxt;
   reg [4:0] cnt_r, cnt_nxt;
   reg [3:0] bit_r, bit_nxt;
   reg phase_r, phase_nxt;
   reg [RES_W-1:0] dac_nxt;
   reg fin_set;
   reg [RES_W-1:0] fin_val;
   reg [RES_W-1:0] val;
   reg [RES_W-1:0] fmt;
   reg [RES_W-1:0] cmp_ref;
   // trigger synchroniser
   reg trg_s1_r, trg_s2_r, trg_s3_r;
   wire conv_en;

   function [2:0] sacf_idx;
      input [ADDR_W-1:0] a;
      begin
         case (a)
            `SACF_OFF_CTRL1: sacf_idx = 3'h0;
            `SACF_OFF_CTRL2: sacf_idx = 3'h1;
            `SACF_OFF_RESULT: sacf_idx = 3'h2;
            `SACF_OFF_CMPVAL: sacf_idx = 3'h3;
            `SACF_OFF_CFG: sacf_idx = 3'h4;
            default: sacf_idx = 3'h7;
         endcase
      end
   endfunction

   function [2:0] sacf_route;
      input [4:0] ch;
      begin
         if (ch <= `SACF_CH_PIN_MAX)
            sacf_route = `SACF_RT_PIN;
         else if (ch <= `SACF_CH_GND_MAX)
            sacf_route = `SACF_RT_GND;
         else if (ch == `SACF_CH_TEMP)
            sacf_route = `SACF_RT_TEMP;
         else if (ch == `SACF_CH_BGAP)
            sacf_route = `SACF_RT_BGAP;
         else if (ch == `SACF_CH_VREFH)
            sacf_route = `SACF_RT_VREFH;
         else if (ch == `SACF_CH_VREFL)
            sacf_route = `SACF_RT_VREFL;
         else if (ch == `SACF_CH_OFF)
            sacf_route = `SACF_RT_OFF;
         else
            sacf_route = `SACF_RT_RSVD;
      end
   endfunction

   // apb decode: a write lands at the access edge, when pready is already high
   wire setup = psel & ~penable;
   wire acc = psel & penable & pready;
   wire wr_acc = acc & pwrite;
   wire rd_acc = acc & ~pwrite;
   wire [2:0] idx = sacf_idx(paddr);
   wire c1_wr = wr_acc & (idx == 3'h0);
   // result read clears the complete flag
   wire res_rd = rd_acc & (idx == 3'h2);
   wire idle = st_r == ST_IDLE;
   // sample window counted in conversion clock enables
   wire [4:0] samp_len = long_r ? `SACF_SAMP_LONG : `SACF_SAMP_SHORT;
   // edge of the synchronised trigger: a long overflow level starts only once
   wire trg_pulse = trg_s2_r & ~trg_s3_r;
   // control 1 write restarts only for a live channel, never in deep stop
   wire start_sw = c1_wr & (pwdata[4:0] != `SACF_CH_OFF) & ~hwt_r & ~deep_stop_mode;
   // overflow starts a conversion in run, wait and light stop
   wire start_hw = hwt_r & trg_pulse & ~c1_wr & (chan_r != `SACF_CH_OFF) & ~deep_stop_mode;
   // in low power only every second enable resolves a bit
   wire step = conv_en & (~lowpow_r | phase_r);

   sacf_clkgen u_clkgen (
      .pclk(pclk),
      .presetn(presetn),
      .run(~idle),
      .src(src_r),
      .div(div_r),
      .light_stop(light_stop_mode),
      .local_osc(local_osc),
      .external_reference_clock(external_reference_clock),
      .conv_en(conv_en)
   );

   // sequencer next state
   always @* begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      bit_nxt = bit_r;
      phase_nxt = phase_r;
      dac_nxt = dac_r;
      fin_set = 1'b0;
      fin_val = result_r;
      val = dac_r;
      fmt = dac_r;
      cmp_ref = cmpval_r;
      // a control 1 write or deep stop always lands in idle first
      if (c1_wr | deep_stop_mode) begin
         st_nxt = ST_IDLE;
         dac_nxt = {RES_W{1'b0}};
      end
      // a start while busy restarts sampling from the first count
      if (start_sw | start_hw) begin
         st_nxt = ST_SAMP;
         cnt_nxt = 5'h00;
      end else if (!(c1_wr | deep_stop_mode)) begin
         case (st_r)
            ST_IDLE: begin
               // idle waits for a software or hardware start
               st_nxt = ST_IDLE;
            end
            ST_SAMP: begin
               if (conv_en) begin
                  // short or long sample window
                  if (cnt_r == samp_len - 5'h01) begin
                     // first trial code has only its top bit set
                     st_nxt = ST_CONV;
                     bit_nxt = 4'h9;
                     phase_nxt = 1'b0;
                     dac_nxt = {1'b1, {(RES_W-1){1'b0}}};
                  end else begin
                     cnt_nxt = cnt_r + 5'h01;
                  end
               end
            end
            ST_CONV: begin
               // low power spends two conversion clocks per bit
               if (conv_en)
                  phase_nxt = ~phase_r;
               if (step) begin
                  // keep the trial bit when input is at or above it
                  val = sar_cmp ? dac_r : (dac_r & ~({{(RES_W-1){1'b0}}, 1'b1} << bit_r));
                  if (bit_r == 4'h0) begin
                     fmt = mode8_r ? {2'h0, val[9:2]} : val;
                     cmp_ref = mode8_r ? {2'h0, cmpval_r[7:0]} : cmpval_r;
                     // compare gates the flag and the result
                     fin_set = ~cmp_en_r | (cmp_gte_r ? (fmt >= cmp_ref) : (fmt < cmp_ref));
                     fin_val = fmt;
                     dac_nxt = {RES_W{1'b0}};
                     if (cont_r & (chan_r != `SACF_CH_OFF)) begin
                        st_nxt = ST_SAMP;
                        cnt_nxt = 5'h00;
                     end else begin
                        st_nxt = ST_IDLE;
                     end
                  end else begin
                     dac_nxt = val | ({{(RES_W-1){1'b0}}, 1'b1} << (bit_r - 4'h1));
                     bit_nxt = bit_r - 4'h1;
                  end
               end
            end
            default: begin
               st_nxt = ST_IDLE;
            end
         endcase
      end
   end

   // apb answer: one access phase, no wait states
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= setup;
         // unmapped offsets answer with an error and read as zero
         pslverr <= setup & (idx == 3'h7);
         // read data is taken at the end of setup and stands through the access
         if (setup & ~pwrite) begin
            case (idx)
               3'h0: prdata <= {24'h000000, done_r, ien_r, cont_r, chan_r};
               3'h1: prdata <= {24'h000000, ~idle, hwt_r, cmp_en_r, cmp_gte_r, 4'h0};
               3'h2: prdata <= {22'h000000, result_r};
               3'h3: prdata <= {22'h000000, cmpval_r};
               3'h4: prdata <= {25'h0000000, lowpow_r, div_r, long_r, mode8_r, src_r};
               default: prdata <= 32'h00000000;
            endcase
         end
      end
   end

   // software registers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chan_r <= `SACF_RST_CHAN;
         cont_r <= 1'b0;
         ien_r <= 1'b0;
         cmp_gte_r <= 1'b0;
         cmp_en_r <= 1'b0;
         hwt_r <= 1'b0;
         src_r <= `SACF_RST_SRC;
         mode8_r <= 1'b0;
         long_r <= 1'b0;
         div_r <= 2'h0;
         lowpow_r <= 1'b0;
         cmpval_r <= {RES_W{1'b0}};
      end else if (wr_acc) begin
         // status bits are read only; result and unmapped writes are dropped
         case (idx)
            3'h0: begin
               chan_r <= pwdata[4:0];
               cont_r <= pwdata[`SACF_C1_CONT];
               ien_r <= pwdata[`SACF_C1_IEN];
            end
            3'h1: begin
               cmp_gte_r <= pwdata[`SACF_C2_CMP_GTE];
               cmp_en_r <= pwdata[`SACF_C2_CMP_EN];
               hwt_r <= pwdata[`SACF_C2_HWT];
            end
            3'h3: begin
               cmpval_r <= pwdata[RES_W-1:0];
            end
            3'h4: begin
               src_r <= pwdata[1:0];
               mode8_r <= pwdata[`SACF_CFG_MODE8];
               long_r <= pwdata[`SACF_CFG_LONG];
               div_r <= pwdata[5:4];
               lowpow_r <= pwdata[`SACF_CFG_LOWPOW];
            end
            default: begin
               cmpval_r <= cmpval_r;
            end
         endcase
      end
   end

   // sequencer, flag and analog side outputs
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= ST_IDLE;
         cnt_r <= 5'h00;
         bit_r <= 4'h0;
         phase_r <= 1'b0;
         dac_r <= {RES_W{1'b0}};
         result_r <= {RES_W{1'b0}};
         done_r <= 1'b0;
         irq_r <= 1'b0;
         sample_r <= 1'b0;
         conv_on_r <= 1'b0;
         route_r <= `SACF_RT_OFF;
         pin_sel_r <= 4'h0;
         trg_s1_r <= 1'b0;
         trg_s2_r <= 1'b0;
         trg_s3_r <= 1'b0;
      end else begin
         // trigger synchronised and edge detected
         trg_s1_r <= hardware_trigger_input;
         trg_s2_r <= trg_s1_r;
         trg_s3_r <= trg_s2_r;
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         bit_r <= bit_nxt;
         phase_r <= phase_nxt;
         dac_r <= dac_nxt;
         // a false compare leaves result and flag as they were
         if (fin_set)
            result_r <= fin_val;
         // completion wins over a same-cycle clear
         if (fin_set)
            done_r <= 1'b1;
         else if (c1_wr | res_rd)
            done_r <= 1'b0;
         // interrupt follows the flag level, so clearing the flag drops it
         irq_r <= ien_r & (done_r | fin_set);
         // sample and converter enable follow the next state to line up with the sequencer; routing follows the channel field
         sample_r <= st_nxt == ST_SAMP;
         // off code isolates; idle drops to low power
         conv_on_r <= (st_nxt != ST_IDLE) & (chan_r != `SACF_CH_OFF);
         route_r <= sacf_route(chan_r);
         pin_sel_r <= chan_r[3:0];
      end
   end
endmodule // sacf_top
`default_nettype wire

// >>> sacf_asserts.sv
// port-level checks of the sar adc control front end
`default_nettype none
`include "sacf_consts.vh"
module sacf_asserts #(
   parameter RES_W = 10,
   parameter ADDR_W = 12
) (
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // sources, trigger and modes
   input wire logic local_osc,
   input wire logic external_reference_clock,
   input wire logic hardware_trigger_input,
   input wire logic light_stop_mode,
   input wire logic deep_stop_mode,
   // analog side
   input wire logic sar_cmp,
   input wire logic [3:0] pin_sel_r,
   input wire logic [2:0] route_r,
   input wire logic conv_on_r,
   input wire logic sample_r,
   input wire logic [RES_W-1:0] dac_r,
   input wire logic irq_r
);
   localparam logic [RES_W-1:0] TOP = 1 << (RES_W - 1);
   logic [4:0] ch_r;
   wire logic wr1 = psel && penable && pready && pwrite && paddr == `SACF_OFF_CTRL1;
   wire logic mapped = paddr <= `SACF_OFF_CFG && paddr[1:0] == 2'h0;
   // channel field as last written over the bus
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) ch_r <= `SACF_RST_CHAN;
      else if (wr1) ch_r <= pwdata[4:0];
   end
   function automatic logic [2:0] rt(input logic [4:0] c);
      if (c <= `SACF_CH_PIN_MAX) return `SACF_RT_PIN;
      if (c <= `SACF_CH_GND_MAX) return `SACF_RT_GND;
      case (c)
         `SACF_CH_TEMP: return `SACF_RT_TEMP;
         `SACF_CH_BGAP: return `SACF_RT_BGAP;
         `SACF_CH_VREFH: return `SACF_RT_VREFH;
         `SACF_CH_VREFL: return `SACF_RT_VREFL;
         `SACF_CH_OFF: return `SACF_RT_OFF;
         default: return `SACF_RT_RSVD;
      endcase
   endfunction
   function automatic logic [RES_W-1:0] lo(input logic [RES_W-1:0] x);
      return x & (~x + 1'h1);
   endfunction
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence ack_s;
      pready ##1 !pready;
   endsequence
   apb_ack_a:
      assert property (setup_s |=> ack_s) else $error("pready not one cycle after setup");
   apb_err_a:
      assert property (pready |-> pslverr == !mapped) else $error("pslverr wrong for address");
   chan_route_a:
      assert property (sample_r && $stable(ch_r) |-> route_r == rt(ch_r) && pin_sel_r == ch_r[3:0])
      else $error("routing does not match channel");
   off_idle_a:
      assert property (route_r == `SACF_RT_OFF |-> !conv_on_r) else $error("converter on while off");
   irq_clear_a:
      assert property (wr1 |=> ##1 !irq_r) else $error("irq kept after control write");
   dac_idle_a:
      assert property (!conv_on_r |-> dac_r == '0) else $error("trial code not zero in idle");
   sar_step_a:
      assert property (conv_on_r && $past(conv_on_r) && dac_r != $past(dac_r) && dac_r != '0 &&
         $past(dac_r) != '0 && dac_r != TOP |-> lo(dac_r) == lo($past(dac_r)) >> 1)
      else $error("trial code did not move one bit down");
   samp_min_a:
      assert property ($rose(sample_r) |-> sample_r [*4]) else $error("sample shorter than four");
   deep_idle_a:
      assert property (deep_stop_mode [*3] |-> !conv_on_r && !sample_r) else $error("busy in deep stop");
endmodule // sacf_asserts
bind sacf_top sacf_asserts #(.RES_W(RES_W), .ADDR_W(ADDR_W)) u_chk (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .local_osc, .external_reference_clock,
   .hardware_trigger_input, .light_stop_mode, .deep_stop_mode, .sar_cmp, .pin_sel_r, .route_r,
   .conv_on_r, .sample_r, .dac_r, .irq_r);
`default_nettype wire

// >>> sacf_analog.sv
// analog side model: source levels as codes, compared with the trial code
`default_nettype none
`include "sacf_consts.vh"
module sacf_analog #(
   parameter logic [9:0] TMP = 10'h15C,
   parameter logic [9:0] BGP = 10'h1A3
) (
   // from the block
   input wire logic [3:0] pin_sel_r,
   input wire logic [2:0] route_r,
   input wire logic conv_on_r,
   input wire logic [9:0] dac_r,
   // comparator
   output logic sar_cmp
);
   logic [9:0] lvl;
   always_comb begin
      case (route_r)
         `SACF_RT_PIN: lvl = {pin_sel_r, 6'h15};
         `SACF_RT_TEMP: lvl = TMP;
         `SACF_RT_BGAP: lvl = BGP;
         `SACF_RT_VREFH: lvl = 10'h3FF;
         `SACF_RT_RSVD: lvl = dac_r ^ 10'h2AA;
         default: lvl = 10'h000;
      endcase
   end
   // isolated converter: comparator stays low
   assign sar_cmp = conv_on_r && lvl >= dac_r;
endmodule // sacf_analog
`default_nettype wire

// >>> sacf_top_tb.sv
// self-checking bench for the sar adc control front end
`default_nettype none
`include "sacf_consts.vh"
module sacf_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [9:0] TMP = 10'h15C;
   localparam logic [9:0] BGP = 10'h1A3;
   logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, err_q;
   logic local_osc = 1'h0, external_reference_clock = 1'h0, hardware_trigger_input = 1'h0;
   logic light_stop_mode = 1'h0, deep_stop_mode = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, rd_q;
   wire logic [31:0] prdata;
   wire logic pready, pslverr, sar_cmp, conv_on_r, sample_r, irq_r;
   wire logic [3:0] pin_sel_r;
   wire logic [2:0] route_r;
   wire logic [9:0] dac_r;
   int err_count = 0, checks_done = 0;
   logic [4:0] chl [7] = '{5'h00, 5'h07, 5'h0F, 5'h10, 5'h15, 5'h1D, 5'h1E};
   sacf_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .local_osc, .external_reference_clock, .hardware_trigger_input, .light_stop_mode,
      .deep_stop_mode, .sar_cmp, .pin_sel_r, .route_r, .conv_on_r, .sample_r, .dac_r, .irq_r);
   sacf_analog #(.TMP(TMP), .BGP(BGP)) u_ana (.pin_sel_r, .route_r, .conv_on_r, .dac_r, .sar_cmp);
   initial forever #4 pclk = ~pclk;
   initial begin
      #3;
      forever #14 local_osc = ~local_osc;
   end
   initial #1 forever #20 external_reference_clock = ~external_reference_clock;
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         err_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic xf(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      rd_q = prdata;
      err_q = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic wflag();
      rd_q = 32'h0;
      for (int n = 0; n < 150 && rd_q[7] !== 1'h1; n++) xf(1'h0, `SACF_OFF_CTRL1, 32'h0);
   endtask
   function automatic logic [31:0] ex(input logic [4:0] c);
      if (c <= 5'h0F) return {22'h0, c[3:0], 6'h15};
      case (c)
         5'h1A: return {22'h0, TMP};
         5'h1B: return {22'h0, BGP};
         5'h1D: return 32'h3FF;
         default: return 32'h0;
      endcase
   endfunction
   task automatic cv(input logic [31:0] cfg, input logic [4:0] ch, input logic [31:0] e);
      xf(1'h1, `SACF_OFF_CFG, cfg);
      xf(1'h1, `SACF_OFF_CTRL1, {27'h0, ch});
      wflag();
      chk(rd_q & 32'h80, 32'h80);
      xf(1'h0, `SACF_OFF_RESULT, 32'h0);
      chk(rd_q, e);
   endtask
   task automatic pulse();
      hardware_trigger_input <= 1'h1;
      repeat (4) @(posedge pclk);
      hardware_trigger_input <= 1'h0;
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge pclk);
      err_count++;
      report_and_stop();
   end
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'h1;
      xf(1'h0, `SACF_OFF_CTRL1, 32'h0);
      chk(rd_q, 32'h1F);
      xf(1'h1, 12'h020, 32'hFFFF);
      xf(1'h0, 12'h020, 32'h0);
      chk({rd_q[30:0], err_q}, 32'h1);
      $display("test 1 done");
      foreach (chl[i]) cv(32'h0, chl[i], ex(chl[i]));
      cv(32'h08, 5'h1B, ex(5'h1B));
      cv(32'h08, 5'h1A, ex(5'h1A));
      xf(1'h1, `SACF_OFF_CTRL1, 32'h16);
      wflag();
      chk(rd_q & 32'h80, 32'h80);
      xf(1'h0, `SACF_OFF_CTRL2, 32'h0);
      chk(rd_q & 32'h80, 32'h0);
      $display("test 2 done");
      cv(32'h44, 5'h09, ex(5'h09) >> 2);
      for (int s = 0; s < 4; s++) cv(32'h10 | s, 5'h03, ex(5'h03));
      cv(32'h30, 5'h02, ex(5'h02));
      light_stop_mode <= 1'h1;
      cv(32'h0, 5'h04, ex(5'h04));
      xf(1'h1, `SACF_OFF_CFG, 32'h03);
      xf(1'h1, `SACF_OFF_CTRL1, 32'h04);
      repeat (300) @(posedge pclk);
      xf(1'h0, `SACF_OFF_CTRL1, 32'h0);
      chk(rd_q, 32'h04);
      light_stop_mode <= 1'h0;
      wflag();
      chk(rd_q & 32'h80, 32'h80);
      $display("test 3 done");
      xf(1'h1, `SACF_OFF_CFG, 32'h0);
      xf(1'h1, `SACF_OFF_CTRL1, 32'h25);
      wflag();
      xf(1'h0, `SACF_OFF_RESULT, 32'h0);
      wflag();
      chk(rd_q & 32'h80, 32'h80);
      xf(1'h1, `SACF_OFF_CTRL1, 32'h3F);
      repeat (60) @(posedge pclk);
      xf(1'h0, `SACF_OFF_CTRL1, 32'h0);
      chk(rd_q, 32'h3F);
      xf(1'h1, `SACF_OFF_CTRL1, 32'h40);
      repeat (6) @(posedge pclk);
      xf(1'h1, `SACF_OFF_CTRL1, 32'h4F);
      wflag();
      chk({31'h0, irq_r}, 32'h1);
      xf(1'h0, `SACF_OFF_RESULT, 32'h0);
      chk(rd_q, ex(5'h0F));
      repeat (2) @(posedge pclk);
      chk({31'h0, irq_r}, 32'h0);
      $display("test 4 done");
      xf(1'h1, `SACF_OFF_CMPVAL, ex(5'h05) + 32'h1);
      xf(1'h1, `SACF_OFF_CTRL2, 32'h20);
      cv(32'h0, 5'h05, ex(5'h05));
      xf(1'h1, `SACF_OFF_CTRL2, 32'h30);
      xf(1'h1, `SACF_OFF_CTRL1, 32'h00);
      repeat (80) @(posedge pclk);
      xf(1'h0, `SACF_OFF_RESULT, 32'h0);
      chk(rd_q, ex(5'h05));
      cv(32'h0, 5'h1D, 32'h3FF);
      $display("test 5 done");
      xf(1'h1, `SACF_OFF_CTRL2, 32'h40);
      xf(1'h1, `SACF_OFF_CTRL1, 32'h0C);
      repeat (60) @(posedge pclk);
      xf(1'h0, `SACF_OFF_CTRL1, 32'h0);
      chk(rd_q, 32'h0C);
      for (int k = 0; k < 2; k++) begin
         light_stop_mode <= 1'(k);
         pulse();
         wflag();
         chk(rd_q & 32'h80, 32'h80);
         xf(1'h0, `SACF_OFF_RESULT, 32'h0);
         chk(rd_q, ex(5'h0C));
      end
      light_stop_mode <= 1'h0;
      xf(1'h1, `SACF_OFF_CTRL2, 32'h0);
      xf(1'h1, `SACF_OFF_CTRL1, 32'h07);
      // abort right after the first of the bit steps, just past the sample window
      repeat (6) @(posedge pclk);
      deep_stop_mode <= 1'h1;
      repeat (40) @(posedge pclk);
      deep_stop_mode <= 1'h0;
      repeat (40) @(posedge pclk);
      xf(1'h0, `SACF_OFF_CTRL1, 32'h0);
      chk(rd_q, 32'h07);
      $display("test 6 done");
      report_and_stop();
   end
endmodule // sacf_top_tb
`default_nettype wire
